// ==== design/cacd_host_ctrl.v ====
// Host controller driving a storage card's memory-card bus pins
// What this block does
// - Attribute read: register select, read strobe held
// - Enables and strobes released between consecutive cycles
// - Attribute writes only to even offsets 0x200..0x20E of the configuration block
// - Reserved index bits 5..4 written as zero
// - Socket-and-copy written before configuration index
`timescale 1ns/1ps
`default_nettype none
`include "cacd_consts.vh"

module cacd_host_ctrl #(
  parameter ADDR_W = 11,
  parameter DATA_W = 16
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // User command port
  input wire cmd_valid,
  output reg cmd_ready,
  input wire cmd_write,
  input wire cmd_attr,
  input wire cmd_word,
  input wire [ADDR_W-1:0] cmd_addr,
  input wire [DATA_W-1:0] cmd_wdata,
  // User response port
  output reg rsp_valid,
  output reg rsp_error,
  output reg [DATA_W-1:0] rsp_rdata,
  // Shadow of the card's configuration option register
  output reg soft_reset_bit,
  output reg level_interrupt_select,
  output reg [5:0] config_index,
  output reg io_mapped,
  // Card bus pins
  output reg even_byte_enable_n,
  output reg odd_byte_enable_n,
  output reg reg_select_n,
  output reg out_enable_n,
  output reg write_enable_n,
  output reg [ADDR_W-1:0] card_addr,
  output reg [DATA_W-1:0] card_data_o,
  output reg card_data_oe,
  input wire [DATA_W-1:0] card_data_i
);

  // ==========================================================
  // States and phase lengths
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_SETUP = 3'h1;
  localparam [2:0] ST_STROBE = 3'h2;
  localparam [2:0] ST_HOLD = 3'h3;
  localparam [2:0] ST_GAP = 3'h4;
  localparam integer SETUP_CYC = `CACD_SETUP_CYC;
  localparam integer STROBE_CYC = `CACD_STROBE_CYC;
  localparam integer HOLD_CYC = `CACD_HOLD_CYC;
  localparam integer GAP_CYC = `CACD_GAP_CYC;
  reg [2:0] state_reg;
  reg op_write_reg;
  reg op_attr_reg;
  reg op_word_reg;
  reg op_odd_reg;
  reg [ADDR_W-1:0] op_addr_reg;
  reg [7:0] op_wbyte_reg;
  reg socket_written_reg;
  reg tmr_load;
  reg [7:0] tmr_val;
  wire tmr_done;
  wire cmd_take;
  wire refused;

  // ==========================================================
  // Decoding helpers
  // True when the address is the configuration register block
  function is_cfg_addr;
    input [ADDR_W-1:0] a;
    begin
      is_cfg_addr = (a[10:9] == 2'b01) && (a[8:4] == 5'h00) &&
        (a[0] == 1'b0);
    end
  endfunction

  // True when the address hits a given configuration register
  function is_reg;
    input [ADDR_W-1:0] a;
    input [ADDR_W-1:0] ofs;
    begin
      is_reg = is_cfg_addr(a) && (a[3:1] == ofs[3:1]);
    end
  endfunction

  // ==========================================================
  // Refusal: illegal accesses never reach the pins
  assign cmd_take = cmd_valid && cmd_ready && (state_reg == ST_IDLE);
  assign refused = (cmd_attr && cmd_word) ||
    (cmd_attr && cmd_addr[0]) ||
    (cmd_attr && cmd_write && !is_cfg_addr(cmd_addr)) ||
    (cmd_attr && cmd_write && is_reg(cmd_addr, `CACD_OFS_CFG_OPTION) &&
      (cmd_wdata[`CACD_IDX_MSB:`CACD_IDX_RSV_LSB] != 2'b00)) ||
    (cmd_attr && cmd_write && is_reg(cmd_addr, `CACD_OFS_CFG_OPTION) &&
      !socket_written_reg) ||
    (!cmd_attr && cmd_word && cmd_addr[0]);

  // ==========================================================
  // Phase timer
  cacd_phase_timer #(
    .WIDTH(8)
  ) u_timer (
    .clk(clk),
    .rst(rst),
    .load(tmr_load),
    .load_val(tmr_val),
    .done(tmr_done)
  );

  // Timer reload at each phase boundary
  always @* begin
    tmr_load = 1'b0;
    tmr_val = SETUP_CYC[7:0];
    if (cmd_take && !refused) begin
      tmr_load = 1'b1;
    end else if (tmr_done) begin
      case (state_reg)
        ST_SETUP: begin
          tmr_load = 1'b1;
          tmr_val = STROBE_CYC[7:0];
        end
        ST_STROBE: begin
          tmr_load = 1'b1;
          tmr_val = HOLD_CYC[7:0];
        end
        ST_HOLD: begin
          tmr_load = 1'b1;
          tmr_val = GAP_CYC[7:0];
        end
        default: tmr_load = 1'b0;
      endcase
    end
  end

  // ==========================================================
  // Access sequencer and pin drivers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_error <= 1'b0;
      rsp_rdata <= {DATA_W{1'b0}};
      op_write_reg <= 1'b0;
      op_attr_reg <= 1'b0;
      op_word_reg <= 1'b0;
      op_odd_reg <= 1'b0;
      op_addr_reg <= {ADDR_W{1'b0}};
      op_wbyte_reg <= 8'h00;
      even_byte_enable_n <= 1'b1;
      odd_byte_enable_n <= 1'b1;
      reg_select_n <= 1'b1;
      out_enable_n <= 1'b1;
      write_enable_n <= 1'b1;
      card_addr <= {ADDR_W{1'b0}};
      card_data_o <= {DATA_W{1'b0}};
      card_data_oe <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      rsp_error <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          cmd_ready <= 1'b1;
          if (cmd_take && refused) begin
            rsp_valid <= 1'b1;
            rsp_error <= 1'b1;
          end else if (cmd_take) begin
            cmd_ready <= 1'b0;
            op_write_reg <= cmd_write;
            op_attr_reg <= cmd_attr;
            op_word_reg <= cmd_word;
            op_odd_reg <= cmd_addr[0];
            op_addr_reg <= cmd_addr;
            op_wbyte_reg <= cmd_wdata[7:0];
            card_addr <= cmd_addr;
            reg_select_n <= !cmd_attr;
            // Attribute bytes ride the even enable only
            even_byte_enable_n <= !(cmd_attr || cmd_word ||
              !cmd_addr[0]);
            odd_byte_enable_n <= !(!cmd_attr &&
              (cmd_word || cmd_addr[0]));
            // Odd common byte goes out on the high lane
            if (!cmd_attr && !cmd_word && cmd_addr[0]) begin
              card_data_o <= {cmd_wdata[7:0], 8'h00};
            end else begin
              card_data_o <= cmd_wdata;
            end
            card_data_oe <= cmd_write;
            state_reg <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (tmr_done) begin
            out_enable_n <= op_write_reg;
            write_enable_n <= !op_write_reg;
            state_reg <= ST_STROBE;
          end
        end
        ST_STROBE: begin
          if (tmr_done) begin
            // Read data sampled before the strobe is released
            if (!op_write_reg) begin
              if (op_attr_reg) begin
                rsp_rdata <= {8'h00, card_data_i[7:0]};
              end else if (op_word_reg) begin
                rsp_rdata <= card_data_i;
              end else if (op_odd_reg) begin
                rsp_rdata <= {8'h00, card_data_i[15:8]};
              end else begin
                rsp_rdata <= {8'h00, card_data_i[7:0]};
              end
            end
            // Strobe rises while enables and select stay low
            out_enable_n <= 1'b1;
            write_enable_n <= 1'b1;
            state_reg <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (tmr_done) begin
            even_byte_enable_n <= 1'b1;
            odd_byte_enable_n <= 1'b1;
            reg_select_n <= 1'b1;
            card_data_oe <= 1'b0;
            state_reg <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (tmr_done) begin
            rsp_valid <= 1'b1;
            cmd_ready <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Option register shadow and socket tracking, updated as the
  // write strobe rises so it never runs ahead of the card
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      soft_reset_bit <= 1'b0;
      level_interrupt_select <= 1'b0;
      config_index <= 6'h00;
      io_mapped <= 1'b0;
      socket_written_reg <= 1'b0;
    end else if ((state_reg == ST_STROBE) && tmr_done &&
      op_write_reg && op_attr_reg) begin
      if (is_reg(op_addr_reg, `CACD_OFS_SOCKET_COPY)) begin
        socket_written_reg <= 1'b1;
      end else if (is_reg(op_addr_reg, `CACD_OFS_CFG_OPTION)) begin
        soft_reset_bit <= op_wbyte_reg[`CACD_BIT_SOFT_RESET];
        level_interrupt_select <= op_wbyte_reg[`CACD_BIT_LEVEL_IRQ];
        if (op_wbyte_reg[`CACD_BIT_SOFT_RESET]) begin
          // Soft reset returns the card to its unconfigured state
          config_index <= 6'h00;
          level_interrupt_select <= 1'b0;
          io_mapped <= 1'b0;
          socket_written_reg <= 1'b0;
        end else begin
          config_index <= op_wbyte_reg[`CACD_IDX_MSB:0];
          io_mapped <= (op_wbyte_reg[`CACD_IDX_MSB:0] !=
            `CACD_MODE_MEMORY);
        end
      end
    end
  end

endmodule

`default_nettype wire

// ==== design/cacd_consts.vh ====
// Constants for the card attribute and configuration access controller
`ifndef CACD_CONSTS_VH
`define CACD_CONSTS_VH

// ==========================================================
// Attribute space register offsets
`define CACD_OFS_CFG_OPTION 11'h200
`define CACD_OFS_CARD_STATUS 11'h202
`define CACD_OFS_PIN_REPL 11'h204
`define CACD_OFS_SOCKET_COPY 11'h206

// ==========================================================
// Configuration option register fields
`define CACD_BIT_SOFT_RESET 7
`define CACD_BIT_LEVEL_IRQ 6
`define CACD_IDX_MSB 5
`define CACD_IDX_RSV_LSB 4
`define CACD_CFG_OPTION_RESET 8'h00

// Configuration index modes
`define CACD_MODE_MEMORY 6'h00
`define CACD_MODE_IO_ANY 6'h01
`define CACD_MODE_IO_PRIMARY 6'h02
`define CACD_MODE_IO_SECONDARY 6'h03

// ==========================================================
// Strobe timing, in ns, and derived cycle counts (rounded up)
`define CACD_CLK_MHZ 20
`define CACD_T_SETUP_NS 30
`define CACD_T_STROBE_NS 250
`define CACD_T_HOLD_NS 20
`define CACD_T_GAP_NS 50
`define CACD_NS2CYC(ns) (((ns) * `CACD_CLK_MHZ + 999) / 1000)
`define CACD_SETUP_CYC `CACD_NS2CYC(`CACD_T_SETUP_NS)
`define CACD_STROBE_CYC `CACD_NS2CYC(`CACD_T_STROBE_NS)
`define CACD_HOLD_CYC `CACD_NS2CYC(`CACD_T_HOLD_NS)
`define CACD_GAP_CYC `CACD_NS2CYC(`CACD_T_GAP_NS)

`endif

// ==== design/cacd_phase_timer.v ====
// Down counter that times each phase of a card access
`timescale 1ns/1ps
`default_nettype none

module cacd_phase_timer #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Control
  input wire load,
  input wire [WIDTH-1:0] load_val,
  // Status
  output wire done
);

  reg [WIDTH-1:0] cnt_reg;

  // ==========================================================
  // Counter: a phase loaded with N lasts N cycles
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= {WIDTH{1'b0}};
    end else if (load) begin
      cnt_reg <= load_val;
    end else if (cnt_reg != {WIDTH{1'b0}}) begin
      cnt_reg <= cnt_reg - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // Last cycle of the phase
  assign done = (cnt_reg == {{(WIDTH-1){1'b0}}, 1'b1});

endmodule

`default_nettype wire

// ==== bench/cacd_host_ctrl_props.sv ====
// Checker watching the host controller's card bus pins
`timescale 1ns/1ps
`default_nettype none
module cacd_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Handshake
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  // Card pins
  input wire logic even_byte_enable_n,
  input wire logic odd_byte_enable_n,
  input wire logic reg_select_n,
  input wire logic out_enable_n,
  input wire logic write_enable_n,
  input wire logic [10:0] card_addr,
  input wire logic [15:0] card_data_o,
  input wire logic card_data_oe
);
  // ==============================
  // Socket seen since reset; a soft reset forgets it
  logic sock_ok_reg;
  wire awr = !reg_select_n && !write_enable_n;
  wire act = !(out_enable_n && write_enable_n);
  always @(posedge clk or posedge rst) begin
    if (rst)
      sock_ok_reg <= 1'b0;
    else if ($fell(write_enable_n) && !reg_select_n)
      sock_ok_reg <= card_addr == 11'h206 ||
        (sock_ok_reg && !(card_addr == 11'h200 && card_data_o[7]));
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ==============================
  // Properties
  a_read_no_write: assert property (!out_enable_n |-> write_enable_n)
    else $error("strobes overlap");
  a_read_select_held: assert property ($fell(out_enable_n) &&
    !reg_select_n |-> !reg_select_n [*6]) else $error("select dropped");
  a_released_at_done: assert property (rsp_valid |-> !card_data_oe &&
    even_byte_enable_n && odd_byte_enable_n && out_enable_n &&
    write_enable_n) else $error("pins not released");
  a_attr_even_lane: assert property (!reg_select_n && act |->
    !even_byte_enable_n && odd_byte_enable_n && !card_addr[0])
    else $error("attribute lane wrong");
  a_attr_write_cfg: assert property (awr |-> card_addr[10:9] == 2'b01 &&
    card_addr[8:3] == 6'h00) else $error("attribute write off map");
  a_rsv_index_zero: assert property (awr && card_addr == 11'h200
    |-> card_data_o[5:4] == 2'b00) else $error("reserved bits set");
  a_socket_first: assert property ($fell(write_enable_n) &&
    !reg_select_n && card_addr == 11'h200 |-> sock_ok_reg)
    else $error("option before socket");
  a_word_even: assert property (reg_select_n && act &&
    !even_byte_enable_n && !odd_byte_enable_n |-> !card_addr[0])
    else $error("odd word");
  a_write_hold: assert property ($rose(write_enable_n) |-> card_data_oe
    && $stable(card_addr) && $stable(card_data_o)) else $error("hold lost");
  a_reply_bound: assert property (cmd_valid && cmd_ready |=>
    ##[0:10] rsp_valid) else $error("no reply");
endmodule
bind cacd_host_ctrl cacd_props u_props (.clk, .rst, .cmd_valid,
  .cmd_ready, .rsp_valid, .even_byte_enable_n, .odd_byte_enable_n,
  .reg_select_n, .out_enable_n, .write_enable_n, .card_addr,
  .card_data_o, .card_data_oe);
`default_nettype wire

// ==== bench/cacd_card_model.sv ====
// Behavioural storage card answering the host controller's pins
`timescale 1ns/1ps
`default_nettype none
module cacd_card_model (
  // Reset
  input wire logic rst,
  // Card pins
  input wire logic even_byte_enable_n,
  input wire logic odd_byte_enable_n,
  input wire logic reg_select_n,
  input wire logic out_enable_n,
  input wire logic write_enable_n,
  input wire logic [10:0] card_addr,
  input wire logic [15:0] card_data_o,
  // Data back to the host
  output logic [15:0] card_data_i
);
  // ==============================
  // Common bytes and the four configuration registers
  logic [7:0] mem [0:2047];
  logic [7:0] cfg [0:3];
  logic [15:0] rd_val;
  logic [15:0] last = 16'h5A5A;
  wire [10:0] ea = {card_addr[10:1], 1'b0};
  wire [10:0] oa = {card_addr[10:1], 1'b1};
  // Idle lanes show the inverse of the last value, never a kind zero
  always @* begin
    rd_val = ~last;
    if (!reg_select_n) begin
      if (!even_byte_enable_n && !card_addr[0])
        rd_val[7:0] = card_addr[9] ? cfg[card_addr[2:1]]
          : card_addr[8:1] ^ 8'h3C;
    end else begin
      if (!even_byte_enable_n)
        rd_val[7:0] = mem[ea];
      if (!odd_byte_enable_n)
        rd_val[15:8] = mem[oa];
    end
  end
  assign card_data_i = out_enable_n ? ~last : rd_val;
  always @(posedge out_enable_n)
    last <= rd_val;
  // Writes land as the strobe rises, address and enables still held
  always @(posedge write_enable_n or posedge rst) begin
    if (rst) begin
      cfg[0] <= 8'h00;
    end else if (!reg_select_n) begin
      if (!even_byte_enable_n && !card_addr[0] && card_addr[10:9] == 2'b01
          && card_addr[8:3] == 6'h00)
        cfg[card_addr[2:1]] <= (card_addr[2:1] == 2'b00 && card_data_o[7])
          ? 8'h80 : card_data_o[7:0];
    end else begin
      if (!even_byte_enable_n)
        mem[ea] <= card_data_o[7:0];
      if (!odd_byte_enable_n)
        mem[oa] <= card_data_o[15:8];
    end
  end
endmodule
`default_nettype wire

// ==== bench/cacd_host_ctrl_tb.sv ====
// Self-checking bench for the card host controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  bad_count++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module cacd_host_ctrl_tb;
  // ==============================
  // Signals and counters
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic cmd_attr = 1'b0;
  logic cmd_word = 1'b0;
  logic [10:0] cmd_addr = 11'h000;
  logic [15:0] cmd_wdata = 16'h0000;
  wire cmd_ready, rsp_valid, rsp_error, soft_reset_bit, io_mapped;
  wire level_interrupt_select, card_data_oe, write_enable_n;
  wire even_byte_enable_n, odd_byte_enable_n, reg_select_n, out_enable_n;
  wire [15:0] rsp_rdata, card_data_o, card_data_i;
  wire [10:0] card_addr;
  wire [5:0] config_index;
  int bad_count = 0;
  int check_count = 0;
  int seed = 89824;
  int i;
  int ref_mem[int];
  logic [15:0] d, d2;
  logic [10:0] a;
  cacd_host_ctrl uut (.clk, .rst, .cmd_valid, .cmd_ready, .cmd_write,
    .cmd_attr, .cmd_word, .cmd_addr, .cmd_wdata, .rsp_valid, .rsp_error,
    .rsp_rdata, .soft_reset_bit, .level_interrupt_select, .config_index,
    .io_mapped, .even_byte_enable_n, .odd_byte_enable_n, .reg_select_n,
    .out_enable_n, .write_enable_n, .card_addr, .card_data_o,
    .card_data_oe, .card_data_i);
  cacd_card_model card (.rst, .even_byte_enable_n, .odd_byte_enable_n,
    .reg_select_n, .out_enable_n, .write_enable_n, .card_addr,
    .card_data_o, .card_data_i);
  initial begin
    forever #25 clk = ~clk;
  end
  // ==============================
  // One request; the wait for a reply gives up after 20 cycles if the controller never answers
  task automatic xfer(input logic w, at, wd, input logic [10:0] ad,
      input logic [15:0] wv, input logic er);
    int n;
    while (cmd_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_attr <= at;
    cmd_word <= wd;
    cmd_addr <= ad;
    cmd_wdata <= wv;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_wdata <= 16'($random(seed));
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 20);
    `CHK(rsp_valid, 1'b1)
    `CHK(cmd_ready, 1'b1)
    `CHK(rsp_error, er)
    // Reference model keeps every common byte the host has written
    if (!er && w && !at) begin
      ref_mem[int'(ad)] = wv[7:0];
      if (wd)
        ref_mem[int'(ad) + 1] = wv[15:8];
    end
  endtask
  task automatic rd(input logic at, wd, input logic [10:0] ad,
      input logic [15:0] ex);
    logic [15:0] m;
    xfer(1'b0, at, wd, ad, 16'h0000, 1'b0);
    `CHK(rsp_rdata, ex)
    // Common reads are also held against the reference model
    if (!at) begin
      m = {8'h00, 8'(ref_mem[int'(ad)])};
      if (wd)
        m[15:8] = 8'(ref_mem[int'(ad) + 1]);
      `CHK(rsp_rdata, m)
    end
  endtask
  // After a hardware reset every shadow of the option register reads zero
  task automatic shadow_zero();
    logic [8:0] s;
    s = {io_mapped, soft_reset_bit, level_interrupt_select, config_index};
    `CHK(s, 9'h000)
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ==============================
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    shadow_zero();
    rd(1, 0, 11'h200, 16'h0000);
    xfer(1, 1, 0, 11'h200, 16'h0001, 1);
    xfer(0, 1, 1, 11'h200, 16'h0000, 1);
    xfer(0, 1, 0, 11'h201, 16'h0000, 1);
    xfer(1, 1, 0, 11'h010, 16'h0055, 1);
    xfer(1, 1, 0, 11'h203, 16'h0055, 1);
    xfer(1, 1, 0, 11'h300, 16'h0055, 1);
    xfer(0, 0, 1, 11'h011, 16'h0000, 1);
    rd(1, 0, 11'h010, 16'h0034);
    xfer(1, 1, 0, 11'h202, 16'h0044, 0);
    rd(1, 0, 11'h202, 16'h0044);
    xfer(1, 1, 0, 11'h206, 16'h0000, 0);
    xfer(1, 1, 0, 11'h200, 16'h0010, 1);
    for (i = 0; i < 4; i++) begin
      d = {9'h000, 1'($random(seed)), 4'h0, 2'(i)};
      xfer(1, 1, 0, 11'h200, d, 0);
      `CHK(level_interrupt_select, d[6])
      `CHK({io_mapped, config_index}, {i != 0, d[5:0]})
      rd(1, 0, 11'h200, d);
    end
    // Mid-run hardware reset: shadows and socket flag start over
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    shadow_zero();
    rd(1, 0, 11'h200, 16'h0000);
    xfer(1, 1, 0, 11'h200, 16'h0001, 1);
    xfer(1, 1, 0, 11'h206, 16'h0000, 0);
    xfer(1, 1, 0, 11'h200, 16'h00C3, 0);
    `CHK({soft_reset_bit, level_interrupt_select, config_index}, 8'h80)
    xfer(1, 1, 0, 11'h200, 16'h0001, 1);
    xfer(1, 1, 0, 11'h206, 16'h0000, 0);
    xfer(1, 1, 0, 11'h200, 16'h0000, 0);
    `CHK(soft_reset_bit, 1'b0)
    for (i = 0; i < 6; i++) begin
      a = 11'($random(seed)) & 11'h7FE;
      d = 16'($random(seed));
      d2 = 16'($random(seed));
      xfer(1, 0, 1, a, d, 0);
      xfer(1, 0, 0, a | 11'h001, d2, 0);
      rd(0, 1, a, {d2[7:0], d[7:0]});
      rd(0, 0, a | 11'h001, {8'h00, d2[7:0]});
      rd(0, 0, a, {8'h00, d[7:0]});
    end
    results();
  end
  // Watchdog far beyond the few hundred cycles the sequence needs
  initial begin
    #2000000;
    bad_count++;
    results();
  end
endmodule
`default_nettype wire
